// >>> inc/sadc_pkg.sv
package sadc_pkg;
   localparam int NUM_CH = 6;
   localparam int CODE_W = 14;
   localparam int SLOT_W = 16;
   localparam int DIFF_W = 16;
   localparam logic [6:0] FRAME_SCKS = 7'h60;
   localparam logic [6:0] BIT_LEAD = 7'h02;
   localparam logic [6:0] LAST_EDGE = 7'h5f;
   localparam logic [6:0] CNT_ZERO = 7'h00;
   localparam logic [6:0] CNT_ONE = 7'h01;
   localparam logic [2:0] RUN_NAP = 3'h2;
   localparam logic [2:0] RUN_SLEEP = 3'h4;
   localparam logic [2:0] RUN_ZERO = 3'h0;
   localparam logic [2:0] RUN_ONE = 3'h1;
   localparam logic [2:0] SEL_ALL_MIN = 3'h5;
   localparam logic [2:0] CH_ALL = 3'h6;
   localparam logic [2:0] CH_ONE = 3'h1;
   localparam logic [3:0] DATA_BITS = 4'he;
   localparam logic [3:0] MSB_POS = 4'hd;
   localparam logic [13:0] CODE_UNI_MIN = 14'h0000;
   localparam logic [13:0] CODE_UNI_MAX = 14'h3fff;
   localparam logic [13:0] CODE_BIP_MIN = 14'h2000;
   localparam logic [13:0] CODE_BIP_MAX = 14'h1fff;
   localparam logic signed [15:0] UNI_HI = 16'sh3fff;
   localparam logic signed [15:0] BIP_HI = 16'sh1fff;
   localparam logic signed [15:0] BIP_LO = 16'she000;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CONVCNT = 8'h08;
   localparam logic [7:0] REG_RESULT0 = 8'h10;
   localparam logic [7:0] REG_RESULT5 = 8'h24;
   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_SEL_LSB = 1;
   localparam int CTRL_POL_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [15:0] CONVCNT_RESET = 16'h0000;
   localparam logic [15:0] CONVCNT_ONE = 16'h0001;
   typedef enum logic [2:0] {
      PWR_ACTIVE = 3'b001,
      PWR_NAP = 3'b010,
      PWR_SLEEP = 3'b100
   } sadc_pwr_t;
   typedef struct packed {
      logic polarity;
      logic [2:0] count_sel;
   } sadc_cfg_t;
   localparam sadc_cfg_t CFG_RESET = 4'h0;
endpackage

// >>> verilog/sadc_readout.sv
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module sadc_readout
   import sadc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sck_i,
   input wire logic conversion_trigger_i,
   input wire logic polarity_select_i,
   input wire logic channel_count_select_b0_i,
   input wire logic channel_count_select_b1_i,
   input wire logic channel_count_select_b2_i,
   input wire logic [NUM_CH-1:0][DIFF_W-1:0] sample_diff_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic reference_on_o,
   output logic [2:0] power_state_o
);

   function automatic logic [CODE_W-1:0] sadc_encode(
      input logic signed [DIFF_W-1:0] d,
      input logic polarity_select
   );
      logic [CODE_W-1:0] c;
      c = d[CODE_W-1:0];
      if (!polarity_select) begin
         if (d[DIFF_W-1]) begin
            c = CODE_UNI_MIN;
         end else if (d > UNI_HI) begin
            c = CODE_UNI_MAX;
         end
      end else begin
         if (d < BIP_LO) begin
            c = CODE_BIP_MIN;
         end else if (d > BIP_HI) begin
            c = CODE_BIP_MAX;
         end
      end
      return c;
   endfunction

   function automatic logic [2:0] sadc_nchan(input logic [2:0] sel);
      return (sel >= SEL_ALL_MIN) ? CH_ALL : sel + CH_ONE;
   endfunction

   // pin synchronisers
   logic [2:0] sck_sy;
   logic [2:0] conversion_trigger_sy;
   sadc_cfg_t cfg_s1;
   sadc_cfg_t cfg_s2;
   always_ff @(posedge clk_i) begin
      sck_sy <= {sck_sy[1:0], sck_i};
      conversion_trigger_sy <= {conversion_trigger_sy[1:0], conversion_trigger_i};
      cfg_s1 <= {polarity_select_i, channel_count_select_b2_i,
                 channel_count_select_b1_i, channel_count_select_b0_i};
      cfg_s2 <= cfg_s1;
   end

   wire sck_rise = sck_sy[1] & ~sck_sy[2];
   wire conversion_trigger_rise = conversion_trigger_sy[1] & ~conversion_trigger_sy[2];

   // control state
   logic [4:0] ctrl;
   logic [15:0] conversion_trigger_cnt;
   logic busy;
   logic seen_start;
   logic [6:0] cnt;
   logic [2:0] trig_run;
   sadc_pwr_t pwr;
   sadc_cfg_t cfg_conversion_trigger;
   logic [CODE_W-1:0] res [NUM_CH];

   wire sadc_cfg_t cfg_reg = {ctrl[CTRL_POL_BIT],
                              ctrl[CTRL_SEL_LSB+2:CTRL_SEL_LSB]};
   wire sadc_cfg_t cfg_eff = ctrl[CTRL_OVR_BIT] ? cfg_reg : cfg_s2;
   wire start = conversion_trigger_rise & ~busy;
   wire advance = busy & sck_rise;
   wire frame_end = advance & (cnt == LAST_EDGE);

   // output bit position of the edge being processed
   wire in_stream = cnt >= BIT_LEAD;
   wire [6:0] bit_idx = cnt - BIT_LEAD;
   wire [2:0] slot = bit_idx[6:4];
   wire [3:0] bit_pos = bit_idx[3:0];
   wire [2:0] nchan = sadc_nchan(cfg_conversion_trigger.count_sel);
   wire slot_used = slot < nchan;
   wire data_bit = bit_pos < DATA_BITS;
   wire [2:0] slot_c = slot_used ? slot : RUN_ZERO;
   wire [3:0] msb_off = MSB_POS - bit_pos;
   wire [CODE_W-1:0] slot_word = res[slot_c];
   wire cur_bit = slot_word[msb_off];
   wire drive = in_stream & slot_used & data_bit;

   // power-down edge counting
   wire [2:0] run_inc = (trig_run == RUN_SLEEP) ? trig_run
                                                 : trig_run + RUN_ONE;
   wire [2:0] next_run = sck_rise ? RUN_ZERO :
                         conversion_trigger_rise ? run_inc : trig_run;
   wire sadc_pwr_t next_pwr = (next_run >= RUN_SLEEP) ? PWR_SLEEP :
                              (next_run >= RUN_NAP) ? PWR_NAP :
                              PWR_ACTIVE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_run <= RUN_ZERO;
         pwr <= PWR_ACTIVE;
         reference_on_o <= 1'b1;
         power_state_o <= PWR_ACTIVE;
      end else begin
         trig_run <= next_run;
         pwr <= next_pwr;
         reference_on_o <= (next_pwr != PWR_SLEEP);
         power_state_o <= next_pwr;
      end
   end

   // conversion sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         cnt <= CNT_ZERO;
         seen_start <= 1'b0;
         conversion_trigger_cnt <= CONVCNT_RESET;
         cfg_conversion_trigger <= CFG_RESET;
      end else if (start) begin
         busy <= 1'b1;
         cnt <= CNT_ZERO;
         seen_start <= 1'b1;
         conversion_trigger_cnt <= conversion_trigger_cnt + CONVCNT_ONE;
         cfg_conversion_trigger <= cfg_eff;
      end else if (advance) begin
         cnt <= cnt + CNT_ONE;
         busy <= ~frame_end;
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (rst_i) begin
            res[i] <= CODE_UNI_MIN;
         end else if (start) begin
            res[i] <= sadc_encode(sample_diff_i[i], cfg_eff.polarity);
         end
      end
   end

   // serial data output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sdo_o <= 1'b0;
         sdo_oe_o <= 1'b0;
      end else if (advance) begin
         sdo_oe_o <= drive;
         sdo_o <= drive & cur_bit;
      end else if (sck_rise) begin
         sdo_oe_o <= 1'b0;
         sdo_o <= 1'b0;
      end
   end

   // wishbone slave
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
   wire is_res = (wb_adr_i >= REG_RESULT0) & (wb_adr_i <= REG_RESULT5) &
                 (wb_adr_i[1:0] == 2'h0);
   wire [7:0] res_off = wb_adr_i - REG_RESULT0;
   wire [2:0] res_idx = res_off[4:2];
   wire [31:0] status_word = {20'h0_0000, cnt, busy, seen_start, pwr};
   wire [31:0] rd_data =
      (wb_adr_i == REG_CTRL) ? {27'h000_0000, ctrl} :
      (wb_adr_i == REG_STATUS) ? status_word :
      (wb_adr_i == REG_CONVCNT) ? {16'h0000, conversion_trigger_cnt} :
      is_res ? {18'h0_0000, res[res_idx]} : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rd_data;
         end
         if (wr_ctrl) begin
            ctrl <= wb_dat_i[4:0];
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_edge_at(logic [6:0] n);
      advance && cnt == n;
   endsequence
   sequence s_idle_trig;
      !busy && conversion_trigger_rise;
   endsequence
   sequence s_sleep_wake;
      pwr == PWR_SLEEP && sck_rise;
   endsequence
   sequence s_nap_wake;
      pwr == PWR_NAP && sck_rise;
   endsequence
   sequence s_gap_edge;
      advance && in_stream && bit_pos == DATA_BITS;
   endsequence

   // power-down
   a_wake_on_sck: assert property (sck_rise |=> pwr == PWR_ACTIVE)
      else $error("sck edge did not wake device");
   a_nap_entry: assert property (
      conversion_trigger_rise && !sck_rise && trig_run == RUN_ONE |=> pwr == PWR_NAP)
      else $error("nap not entered after two triggers");
   a_sleep_entry: assert property (
      conversion_trigger_rise && !sck_rise && trig_run == 3'h3 ##1 !sck_rise
      |-> power_state_o == PWR_SLEEP && !reference_on_o)
      else $error("sleep not entered after four triggers");
   a_nap_ref_on: assert property (pwr == PWR_NAP |-> reference_on_o)
      else $error("reference off during nap");
   a_ref_sleep: assert property (
      power_state_o == PWR_SLEEP |-> !reference_on_o)
      else $error("reference on during sleep");
   a_ref_awake: assert property (
      power_state_o != PWR_SLEEP |-> reference_on_o)
      else $error("reference off outside sleep");
   a_nap_hold: assert property (
      pwr == PWR_NAP && !sck_rise && !conversion_trigger_rise |=> pwr == PWR_NAP)
      else $error("nap left without sck edge");
   a_sleep_hold: assert property (
      pwr == PWR_SLEEP && !sck_rise |=> pwr == PWR_SLEEP)
      else $error("sleep left without sck edge");
   a_sleep_wake: assert property (
      s_sleep_wake |=> pwr == PWR_ACTIVE && reference_on_o)
      else $error("sleep not left on sck edge");
   a_nap_wake: assert property (
      s_nap_wake |=> power_state_o == PWR_ACTIVE)
      else $error("nap not left on sck edge");

   // conversion frame
   a_busy_ignore: assert property (
      busy && conversion_trigger_rise |=> $stable(conversion_trigger_cnt) && cfg_conversion_trigger == $past(cfg_conversion_trigger))
      else $error("trigger accepted during frame");
   a_start_busy: assert property (
      s_idle_trig |=> busy && cnt == CNT_ZERO)
      else $error("idle trigger did not start frame");
   a_start_count: assert property (
      s_idle_trig |=> conversion_trigger_cnt == $past(conversion_trigger_cnt) + CONVCNT_ONE)
      else $error("accepted trigger not counted");
   a_frame_len: assert property (s_edge_at(LAST_EDGE) |=> !busy)
      else $error("frame did not end at edge 96");
   a_cnt_step: assert property (
      advance && !frame_end |=> cnt == $past(cnt) + CNT_ONE)
      else $error("edge count did not advance");
   a_idle_hold: assert property (
      !busy && !start |=> $stable(cnt))
      else $error("edge count moved while idle");
   a_res_hold: assert property (
      !start |=> $stable(res[0]))
      else $error("result changed without trigger");

   // serial output
   a_first_msb: assert property (
      s_edge_at(BIT_LEAD) |=> sdo_oe_o && sdo_o == res[0][MSB_POS])
      else $error("msb not driven at third edge");
   a_early_hiz: assert property (s_edge_at(CNT_ONE) |=> !sdo_oe_o)
      else $error("output driven before third edge");
   a_drive_bit: assert property (
      advance && drive |=> sdo_oe_o && sdo_o == $past(cur_bit))
      else $error("data bit not updated on sck edge");
   a_gap_hiz: assert property (
      advance && in_stream && !data_bit |=> !sdo_oe_o)
      else $error("gap bit not high impedance");
   a_gap_first: assert property (
      s_gap_edge |=> !sdo_oe_o && !sdo_o)
      else $error("first gap bit driven");
   a_slot_count: assert property (
      advance && in_stream && !slot_used |=> !sdo_oe_o)
      else $error("unselected slot driven");
   a_hiz_reset: assert property (!seen_start |-> !sdo_oe_o)
      else $error("output driven before first trigger");
   a_sdo_quiet: assert property (!sdo_oe_o |-> !sdo_o)
      else $error("data high while output released");

   // result coding
   a_uni_clamp: assert property (
      start && !cfg_eff.polarity && $signed(sample_diff_i[0]) > UNI_HI
      |=> res[0] == CODE_UNI_MAX)
      else $error("unipolar overrange not clamped");
   a_uni_floor: assert property (
      start && !cfg_eff.polarity && sample_diff_i[0][DIFF_W-1]
      |=> res[0] == CODE_UNI_MIN)
      else $error("unipolar underrange not clamped");
   a_uni_pass: assert property (
      start && !cfg_eff.polarity && !sample_diff_i[0][DIFF_W-1] &&
      $signed(sample_diff_i[0]) <= UNI_HI
      |=> res[0] == $past(sample_diff_i[0][CODE_W-1:0]))
      else $error("unipolar code not straight binary");
   a_bip_clamp: assert property (
      start && cfg_eff.polarity && $signed(sample_diff_i[0]) < BIP_LO
      |=> res[0] == CODE_BIP_MIN)
      else $error("bipolar underrange not clamped");
   a_bip_top: assert property (
      start && cfg_eff.polarity && $signed(sample_diff_i[0]) > BIP_HI
      |=> res[0] == CODE_BIP_MAX)
      else $error("bipolar overrange not clamped");
   a_bip_pass: assert property (
      start && cfg_eff.polarity && $signed(sample_diff_i[0]) >= BIP_LO &&
      $signed(sample_diff_i[0]) <= BIP_HI
      |=> res[0] == $past(sample_diff_i[0][CODE_W-1:0]))
      else $error("bipolar code not two's complement");

   // register port
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ctrl_hold: assert property (!wr_ctrl |=> $stable(ctrl))
      else $error("ctrl changed without write");
endmodule

// >>> test/sadc_host.sv
`timescale 1ns/1ps
// host serial port: makes sck and trigger, captures sdo
module sadc_host
   import sadc_pkg::*;
(
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   output logic sck_o = 1'b0,
   output logic trig_o = 1'b0
);
   logic [95:0] bits;
   logic [95:0] oes;
   // trigger high for one sck period
   task automatic trig();
      #3;
      trig_o = 1'b1;
      #125;
      trig_o = 1'b0;
      #125;
   endtask
   // sck runs only inside frames; optional trigger at edge mid
   task automatic clocks(input int n, input int mid);
      #3;
      for (int i = 0; i < n; i++) begin
         sck_o = 1'b1;
         #62.5;
         sck_o = 1'b0;
         trig_o = (i == mid);
         bits[i % 96] = sdo_i;
         oes[i % 96] = sdo_oe_i;
         #62.5;
      end
      trig_o = 1'b0;
   endtask
endmodule

// >>> test/sadc_readout_test.sv
`timescale 1ns/1ps
module sadc_readout_test
   import sadc_pkg::*;
   ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, wb_rd;
   logic wb_ack_o, sck_i, conversion_trigger_i, sdo_o, sdo_oe_o;
   logic polarity_select_i = 1'b0, reference_on_o;
   logic channel_count_select_b0_i = 1'b0;
   logic channel_count_select_b1_i = 1'b0;
   logic channel_count_select_b2_i = 1'b0;
   logic [NUM_CH-1:0][DIFF_W-1:0] sample_diff_i = '0;
   logic [2:0] power_state_o;
   int failures = 0, checks = 0, cyc_cnt = 0;
   int uni_v[6] = '{-5, 20000, 0, 16383, 12345, 4660};
   int bip_v[6] = '{-9000, 9000, -8192, 8191, -1, 1234};
   always #5 clk_i = ~clk_i;
   sadc_readout i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sck_i,
      .conversion_trigger_i, .polarity_select_i,
      .channel_count_select_b0_i, .channel_count_select_b1_i,
      .channel_count_select_b2_i, .sample_diff_i, .sdo_o, .sdo_oe_o,
      .reference_on_o, .power_state_o);
   sadc_host i_host (.sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .sck_o(sck_i),
      .trig_o(conversion_trigger_i));
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] sl);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= sl;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      wb_rd = wb_dat_o;
      chk("wb_ack_o", 32'h0000_0001, wb_ack_o);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic logic [13:0] code(input int v, input logic bp);
      if (!bp) return v < 0 ? 14'h0000 : v > 16383 ? 14'h3fff : v[13:0];
      return v < -8192 ? 14'h2000 : v > 8191 ? 14'h1fff : v[13:0];
   endfunction
   // one full frame, every edge checked against the slot map
   task automatic frame(input logic [2:0] sl, input logic p, input int cnt,
         input logic bp);
      int s, b;
      logic [13:0] c;
      @(posedge clk_i);
      {channel_count_select_b2_i, channel_count_select_b1_i,
         channel_count_select_b0_i} <= sl;
      polarity_select_i <= p;
      for (int i = 0; i < NUM_CH; i++) begin
         sample_diff_i[i] <= bp ? bip_v[i] : uni_v[i];
      end
      repeat (4) @(posedge clk_i);
      i_host.trig();
      i_host.clocks(96, -1);
      for (int n = 1; n <= 96; n++) begin
         s = (n - 3) / 16;
         b = (n - 3) % 16;
         if (b >= 0 && b < 14 && s < cnt) begin
            c = code(bp ? bip_v[s] : uni_v[s], bp);
            chk("sdo_oe_o", 32'h0000_0001, i_host.oes[n-1]);
            chk("sdo_o", c[13-b], i_host.bits[n-1]);
         end else begin
            chk("sdo_oe_o", 32'h0000_0000, i_host.oes[n-1]);
         end
      end
   endtask
   task automatic power();
      i_host.trig();
      i_host.trig();
      repeat (6) @(posedge clk_i);
      chk("power_state_o", PWR_NAP, power_state_o);
      chk("reference_on_o", 32'h0000_0001, reference_on_o);
      i_host.trig();
      i_host.trig();
      repeat (6) @(posedge clk_i);
      chk("power_state_o", PWR_SLEEP, power_state_o);
      chk("reference_on_o", 32'h0000_0000, reference_on_o);
      i_host.clocks(1, -1);
      repeat (6) @(posedge clk_i);
      chk("power_state_o", PWR_ACTIVE, power_state_o);
      i_host.clocks(95, -1);
   endtask
   task automatic busy();
      logic [31:0] c;
      wb(1'b0, REG_CONVCNT, 32'h0000_0000, 4'h0);
      c = wb_rd;
      i_host.trig();
      i_host.clocks(96, 40);
      wb(1'b0, REG_CONVCNT, 32'h0000_0000, 4'h0);
      chk("convcnt", c + 32'h0000_0001, wb_rd);
   endtask
   task automatic regs();
      wb(1'b0, REG_CTRL, 32'h0000_0000, 4'h0);
      chk("ctrl", CTRL_RESET, wb_rd);
      wb(1'b0, 8'h40, 32'h0000_0000, 4'h0);
      chk("unmapped", 32'h0000_0000, wb_rd);
      wb(1'b1, REG_CTRL, 32'h0000_001b, 4'h0);
      wb(1'b0, REG_CTRL, 32'h0000_0000, 4'h0);
      chk("ctrl", 32'h0000_0000, wb_rd);
      wb(1'b1, REG_CTRL, 32'h0000_001b, 4'h1);
      wb(1'b0, REG_CTRL, 32'h0000_0000, 4'h0);
      chk("ctrl", 32'h0000_001b, wb_rd);
      frame(3'h0, 1'b0, 6, 1'b1);
      wb(1'b0, REG_RESULT0, 32'h0000_0000, 4'h0);
      chk("result0", 32'h0000_2000, wb_rd);
      wb(1'b0, REG_STATUS, 32'h0000_0000, 4'h0);
      chk("status", 32'h0000_0c09, wb_rd);
      wb(1'b1, REG_CTRL, 32'h0000_0000, 4'h1);
   endtask
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("sdo_oe_o", 32'h0000_0000, sdo_oe_o);
      chk("power_state_o", PWR_ACTIVE, power_state_o);
      chk("reference_on_o", 32'h0000_0001, reference_on_o);
      for (int k = 0; k < 8; k++) begin
         frame(k[2:0], 1'b0, k < 5 ? k + 1 : 6, 1'b0);
      end
      frame(3'h5, 1'b1, 6, 1'b1);
      busy();
      power();
      regs();
      finish_test();
   end
endmodule
